// ---- rtl/lowpower_map.svh ----
// register offsets, field positions, reset values and timing counts
// assumes inclusion from the low-power unit and the bench top only
`ifndef LOWPOWER_MAP_SVH
`define LOWPOWER_MAP_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_BREAK_EXIT_STATUS   16'hfe00
`define ADDR_LAST_RESET_SOURCE   16'hfe01
`define ADDR_BREAK_FLAG_CONTROL  16'hfe03
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_BREAK_EXIT_FLAG      1
`define BIT_RST_POWER_ON         7
`define BIT_RST_PIN              6
`define BIT_RST_WATCHDOG         5
`define BIT_RST_BAD_OPCODE       4
`define BIT_RST_BAD_ADDRESS      3
`define BIT_RST_USB              2
`define BIT_BREAK_FLAG_CLEAR_EN  7
// ----------------------------------------
// reset values and recovery counts
// ----------------------------------------
`define RESET_REG_VALUE          8'h00
`define RECOVERY_LONG_CYCLES     4096
`define RECOVERY_SHORT_CYCLES    32
`endif

// ---- rtl/lowpower_pkg.sv ----
// types shared by the low-power and reset-status unit
// assumes the constants header sits beside it
package lowpower_pkg;
    // reset causes reported by the reset generator, one-hot
    typedef struct packed {
        logic powerOn;      // power-on circuit
        logic pin;          // external reset pin
        logic watchdog;     // watchdog timeout
        logic badOpcode;    // illegal opcode
        logic badAddress;   // illegal address, fetch or not
        logic usb;          // usb module reset
    } reset_cause_t;

    // cpu register access
    typedef struct packed {
        logic        rd;    // read strobe
        logic        wr;    // write strobe
        logic [15:0] addr;  // byte address
        logic [7:0]  wdata; // write data
    } reg_access_t;

    // power states, one-hot
    typedef enum logic [3:0] {
        RUN     = 4'b0001,
        WAITING = 4'b0010,
        STOPPED = 4'b0100,
        RECOVER = 4'b1000
    } power_state_t;
endpackage

// ---- rtl/lowpower_unit.sv ----
// low-power mode control and reset/break status registers
// assumes one crystal-derived clock; cpu strobes are on this clock,
// the reset pin and break/interrupt requests are synchronised here
//
// Functional notes
// - low-power instructions clear cpu interrupt mask
// - cpu stays unclocked until mode exit
// - wait gates cpu clocks, peripherals run
// - enabled interrupt wakes wait, stacking next cycle
// - reset or break also leaves wait
// - exit event is pin OR irq OR break
// - break during wait or stop sets break-exit flag
// - watchdog runs in wait unless disabled
// - stop resets counter, gates all system clocks
// - stop exits on irq/reset/break after recovery
// - recovery 4096 cycles, 32 when short selected
// - counter held in stop, then times recovery
// - break-exit flag cleared by zero write, reset
// - reading reset status clears all flags
// - power-on sets its flag, clears others
// - six reset source flags, last cause set
// - bad-address flag only for opcode fetches
// - break-state flag clearing needs enable bit; only flagClearAllowed uses it, fe00 write and fe01 read clear without it
// - three registers at fe00, fe01, fe03
// - flag cleared in break stays cleared
`timescale 1ns/1ps
`include "lowpower_map.svh"
module lowpower_unit #(
    parameter int LONG_RECOVERY  = `RECOVERY_LONG_CYCLES,
    parameter int SHORT_RECOVERY = `RECOVERY_SHORT_CYCLES
) (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // cpu instruction side
    input  wire logic                      waitExec,
    input  wire logic                      stopExec,
    output logic                           clearIntMask,
    output logic                           cpuClockEn,
    output logic                           stackStart,
    // wake sources (asynchronous) and break state
    input  wire logic                      resetPin,
    input  wire logic                      cpuIrq,
    input  wire logic                      breakIrq,
    input  wire logic                      inBreak,
    // reset generator
    input  wire logic                      resetEvent,
    input  wire lowpower_pkg::reset_cause_t resetCause,
    input  wire logic                      badAddrIsFetch,
    // configuration
    input  wire logic                      short_stop_recovery,
    input  wire logic                      watchdog_disable_option,
    // clock gating and peripheral control
    output logic                           base_clock_out_en,
    output logic                           crystal_clock_en,
    output logic                           periphClockEn,
    output logic                           watchdogRun,
    output logic                           lowpower_exit_event,
    output logic                           flagClearAllowed,
    // register access
    input  wire lowpower_pkg::reg_access_t regBus,
    output logic [7:0]                     regRdata
);
    import lowpower_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] syncMeta_q;   // first stage, read only by second
    logic [2:0] syncOut_q;    // usable levels: pin, irq, break
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            syncMeta_q <= 3'h0;
            syncOut_q  <= 3'h0;
        end
        else
        begin
            syncMeta_q <= {breakIrq, cpuIrq, resetPin};
            syncOut_q  <= syncMeta_q;
        end
    end

    logic pinSync;            // reset pin, synchronised
    logic irqSync;            // enabled cpu interrupt
    logic brkSync;            // break interrupt
    assign pinSync = syncOut_q[0];
    assign irqSync = syncOut_q[1];
    assign brkSync = syncOut_q[2];

    // exit event shared by wait and stop
    assign lowpower_exit_event = pinSync | irqSync | brkSync;

    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    power_state_t state_q;    // current power state
    power_state_t state_d;    // next power state
    logic [12:0]  recCnt_q;   // recovery counter
    logic [12:0]  recLimit;   // selected recovery length
    logic         recDone;    // recovery elapsed

    // short recovery is meant for canned oscillators only
    assign recLimit = short_stop_recovery ? 13'(SHORT_RECOVERY)
                                          : 13'(LONG_RECOVERY);
    assign recDone  = (recCnt_q == recLimit - 13'h1);

    // next-state decode
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RUN:
            begin
                if (stopExec)
                    state_d = STOPPED;
                else if (waitExec)
                    state_d = WAITING;
            end
            WAITING:
            begin
                if (lowpower_exit_event)
                    state_d = RUN;
            end
            STOPPED:
            begin
                if (lowpower_exit_event)
                    state_d = RECOVER;
            end
            RECOVER:
            begin
                if (recDone)
                    state_d = RUN;
            end
            default: state_d = RUN;
        endcase
    end

    // state register; a system reset always returns to run
    always_ff @(posedge ref_clk)
    begin
        if (rst || resetEvent)
            state_q <= RUN;
        else
            state_q <= state_d;
    end

    // recovery counter: held at zero until recovery starts
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_q != RECOVER)
            recCnt_q <= 13'h0;
        else
            recCnt_q <= recCnt_q + 13'h1;
    end

    // ----------------------------------------
    // clock gating and cpu hand-back
    // ----------------------------------------
    // cpu clocks off in any low-power state, recovery included
    assign cpuClockEn        = (state_q == RUN);
    assign periphClockEn     = (state_q == RUN) || (state_q == WAITING);
    // oscillator outputs gated only while stopped; recovery counts on them
    assign base_clock_out_en = (state_q != STOPPED);
    assign crystal_clock_en  = (state_q != STOPPED);
    assign watchdogRun       = !watchdog_disable_option && periphClockEn;
    assign clearIntMask      = (state_q == RUN) && (waitExec || stopExec);

    // stacking pulse one cycle after an interrupt wake from wait, or at the end of recovery if the interrupt is still present
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            stackStart <= 1'b0;
        else
            stackStart <= ((state_q == WAITING) && irqSync)
                        || ((state_q == RECOVER) && recDone && irqSync);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    function automatic logic hit(input reg_access_t a, input logic [15:0] addr);
        hit = (a.addr == addr);
    endfunction

    logic breakExitFlag_q;    // break-exit status
    logic [5:0] rstFlags_q;   // reset source flags
    logic clearEnable_q;      // break flag-clear enable

    // break-exit flag: break set wins over software clear
    always_ff @(posedge ref_clk)
    begin
        if (rst || resetEvent)
            breakExitFlag_q <= 1'b0;
        else if (brkSync && (state_q == WAITING || state_q == STOPPED))
            breakExitFlag_q <= 1'b1;
        else if (regBus.wr && hit(regBus, `ADDR_BREAK_EXIT_STATUS)
                 && !regBus.wdata[`BIT_BREAK_EXIT_FLAG])
            breakExitFlag_q <= 1'b0;
    end

    // reset source flags; capture at reset wins over read-clear
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rstFlags_q <= 6'h20;        // powered up
        else if (resetEvent)
        begin
            if (resetCause.powerOn)
                rstFlags_q <= 6'h20;
            else
                rstFlags_q <= {1'b0, resetCause.pin, resetCause.watchdog,
                               resetCause.badOpcode,
                               resetCause.badAddress && badAddrIsFetch,
                               resetCause.usb};
        end
        else if (regBus.rd && hit(regBus, `ADDR_LAST_RESET_SOURCE))
            rstFlags_q <= 6'h00;
    end

    // break flag-clear enable, plain read/write
    always_ff @(posedge ref_clk)
    begin
        if (rst || resetEvent)
            clearEnable_q <= 1'b0;
        else if (regBus.wr && hit(regBus, `ADDR_BREAK_FLAG_CONTROL))
            clearEnable_q <= regBus.wdata[`BIT_BREAK_FLAG_CLEAR_EN];
    end

    // other modules may clear flags outside break, or in break when enabled;
    // a flag cleared then is gone for good, nothing restores it
    assign flagClearAllowed = !inBreak || clearEnable_q;

    // read data, registered; unmapped reads return zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            regRdata <= `RESET_REG_VALUE;
        else if (hit(regBus, `ADDR_BREAK_EXIT_STATUS))
            regRdata <= 8'({breakExitFlag_q, 1'b0});
        else if (hit(regBus, `ADDR_LAST_RESET_SOURCE))
            regRdata <= {rstFlags_q, 2'b00};
        else if (hit(regBus, `ADDR_BREAK_FLAG_CONTROL))
            regRdata <= {clearEnable_q, 7'h00};
        else
            regRdata <= 8'h00;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_cpuGated;
        @(posedge ref_clk) disable iff (rst)
        (state_q != RUN) |-> !cpuClockEn;
    endproperty
    a_cpuGated: assert property (p_cpuGated) else $error("cpu clocked in low power");

    property p_waitPeriph;
        @(posedge ref_clk) disable iff (rst)
        (state_q == WAITING) |-> periphClockEn && !cpuClockEn;
    endproperty
    a_waitPeriph: assert property (p_waitPeriph) else $error("wait gating wrong");

    property p_stopGate;
        @(posedge ref_clk) disable iff (rst)
        (state_q == STOPPED) |-> !base_clock_out_en && !crystal_clock_en && recCnt_q == 13'h0;
    endproperty
    a_stopGate: assert property (p_stopGate) else $error("stop gating wrong");

    property p_waitWake;
        @(posedge ref_clk) disable iff (rst || resetEvent)
        (state_q == WAITING && irqSync) |=> stackStart && state_q == RUN;
    endproperty
    a_waitWake: assert property (p_waitWake) else $error("wait wake late");

    // helper: cycles spent in recovery so far; a long repetition would
    // blow up the checker, so the length is counted here instead
    logic [12:0] recStay_q;
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_q != RECOVER)
            recStay_q <= 13'h0;
        else
            recStay_q <= recStay_q + 13'h1;
    end

    property p_shortRec;
        @(posedge ref_clk) disable iff (rst || resetEvent)
        (state_q == RECOVER && short_stop_recovery)
            |-> if (recStay_q == 13'(SHORT_RECOVERY - 1)) ##1 (state_q == RUN)
                else ##1 (state_q == RECOVER);
    endproperty
    a_shortRec: assert property (p_shortRec) else $error("short recovery length");

    property p_brkFlag;
        @(posedge ref_clk) disable iff (rst || resetEvent)
        (brkSync && state_q == STOPPED) |=> breakExitFlag_q;
    endproperty
    a_brkFlag: assert property (p_brkFlag) else $error("break flag not set");

    property p_rsrClear;
        @(posedge ref_clk) disable iff (rst)
        (regBus.rd && hit(regBus, `ADDR_LAST_RESET_SOURCE) && !resetEvent)
            |=> rstFlags_q == 6'h00;
    endproperty
    a_rsrClear: assert property (p_rsrClear) else $error("reset status not cleared");

    property p_porFlags;
        @(posedge ref_clk) disable iff (rst)
        (resetEvent && resetCause.powerOn) |=> rstFlags_q == 6'h20;
    endproperty
    a_porFlags: assert property (p_porFlags) else $error("power-on flags wrong");

    property p_maskClear;
        @(posedge ref_clk) disable iff (rst || resetEvent)
        (state_q == RUN && waitExec) |-> clearIntMask ##1 (state_q != RUN);
    endproperty
    a_maskClear: assert property (p_maskClear) else $error("mask not cleared");
endmodule

// ---- tb/lowpower_cpu_model.sv ----
// cpu core model facing the low-power unit
// assumes bench asks for wait/stop as levels on the falling edge
`timescale 1ns/1ps
module lowpower_cpu_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // bench requests
    input  wire logic goWait,
    input  wire logic goStop,
    // unit side
    input  wire logic cpuClockEn,
    input  wire logic stackStart,
    output logic      waitExec,
    output logic      stopExec,
    output int        stackCnt
);
    // an unclocked core cannot issue any instruction
    assign waitExec = goWait & cpuClockEn;
    assign stopExec = goStop & cpuClockEn;
    // ------------------------------
    // interrupt entries seen
    // ------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            stackCnt <= 0;
        else if (stackStart)
            stackCnt <= stackCnt + 1;
    end
endmodule

// ---- tb/lowpower_unit_tb_top.sv ----
// self-checking bench for the low-power and reset-status unit
// assumes the cpu model beside it; long recovery shortened to 64
`timescale 1ns/1ps
`include "lowpower_map.svh"
module lowpower_unit_tb_top;
    import lowpower_pkg::*;
    localparam int LONG_REC  = 64; // keeps run short
    localparam int SHORT_REC = 32;
    // ------------------------------
    // stimulus, observed outputs, model state
    // ------------------------------
    logic         ref_clk, rst, goWait, goStop, resetPin, cpuIrq, breakIrq;
    logic         inBreak, resetEvent, badAddrIsFetch, shortRec, wdDisable;
    logic         waitExec, stopExec, clearIntMask, cpuClockEn, stackStart;
    logic         baseEn, xtalEn, periphClockEn, watchdogRun, exitEvt, clrOk;
    reset_cause_t resetCause;
    reg_access_t  regBus;
    logic [7:0]   regRdata;
    logic [5:0]   expRst;  // model of the reset flags
    logic         expBrk;  // model of the break-exit flag
    logic         expEn;   // model of the clear enable
    logic [31:0]  rng;
    int           stackCnt, error_cnt, n_checks, n, rec;

    lowpower_unit #(.LONG_RECOVERY(LONG_REC), .SHORT_RECOVERY(SHORT_REC)) DUT (
        .ref_clk(ref_clk), .rst(rst), .waitExec(waitExec), .stopExec(stopExec),
        .clearIntMask(clearIntMask), .cpuClockEn(cpuClockEn), .stackStart(stackStart),
        .resetPin(resetPin), .cpuIrq(cpuIrq), .breakIrq(breakIrq), .inBreak(inBreak),
        .resetEvent(resetEvent), .resetCause(resetCause), .badAddrIsFetch(badAddrIsFetch),
        .short_stop_recovery(shortRec), .watchdog_disable_option(wdDisable),
        .base_clock_out_en(baseEn), .crystal_clock_en(xtalEn),
        .periphClockEn(periphClockEn), .watchdogRun(watchdogRun),
        .lowpower_exit_event(exitEvt), .flagClearAllowed(clrOk),
        .regBus(regBus), .regRdata(regRdata));

    lowpower_cpu_model cpuModel (
        .ref_clk(ref_clk), .rst(rst), .goWait(goWait), .goStop(goStop),
        .cpuClockEn(cpuClockEn), .stackStart(stackStart), .waitExec(waitExec),
        .stopExec(stopExec), .stackCnt(stackCnt));

    always #2 ref_clk = ~ref_clk;

    // ------------------------------
    // compare, verdict, random source
    // ------------------------------
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_reg(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // ------------------------------
    // register access, data answered one edge after address
    // ------------------------------
    task automatic rd_chk(input logic [15:0] a);
        logic [7:0] e;
        case (a)
            `ADDR_BREAK_EXIT_STATUS:  e = {6'h00, expBrk, 1'b0};
            `ADDR_LAST_RESET_SOURCE:  e = {expRst, 2'h0};
            `ADDR_BREAK_FLAG_CONTROL: e = {expEn, 7'h00};
            default:                  e = 8'h00;
        endcase
        @(negedge ref_clk);
        regBus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        regBus.rd = 1'b0;
        chk_reg("regRdata", e, regRdata);
        // reading the reset flags empties them
        if (a == `ADDR_LAST_RESET_SOURCE)
            expRst = 6'h00;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regBus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge ref_clk);
        regBus.wr = 1'b0;
        if (a == `ADDR_BREAK_FLAG_CONTROL)
            expEn = d[7];
        if (a == `ADDR_BREAK_EXIT_STATUS && !d[1])
            expBrk = 1'b0;
    endtask
    task automatic rst_evt(input reset_cause_t c, input logic fetch);
        @(negedge ref_clk);
        resetEvent = 1'b1;
        resetCause = c;
        badAddrIsFetch = fetch;
        @(negedge ref_clk);
        resetEvent = 1'b0;
        expRst = c;
        expRst[1] = c.badAddress & fetch;
        expBrk = 1'b0;
        expEn = 1'b0;
    endtask
    // ------------------------------
    // low-power entry and bounded wait for the cpu clock
    // ------------------------------
    task automatic enter(input logic stop);
        @(negedge ref_clk);
        goWait = !stop;
        goStop = stop;
        #1;
        chk_bit("clearIntMask", 1'b1, clearIntMask);
        @(negedge ref_clk);
        goWait = 1'b0;
        goStop = 1'b0;
        chk_bit("cpuClockEn", 1'b0, cpuClockEn);
        chk_bit("periphClockEn", !stop, periphClockEn);
        chk_bit("xtalEn", !stop, xtalEn);
        chk_bit("baseEn", !stop, baseEn);
        chk_bit("watchdogRun", !stop & !wdDisable, watchdogRun);
    endtask
    task automatic run_back(input int lim);
        n = 0;
        rec = 0;
        while (cpuClockEn !== 1'b1 && n < lim)
        begin
            @(negedge ref_clk);
            n++;
            if (cpuClockEn !== 1'b1 && xtalEn === 1'b1)
                rec++;
        end
        if (n >= lim)
        begin
            error_cnt++;
            $display("MISMATCH cpuClockEn expected 1 seen stuck");
            give_verdict();
        end
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial
    begin
        {ref_clk, goWait, goStop, resetPin, cpuIrq, breakIrq, inBreak} = '0;
        {resetEvent, badAddrIsFetch, wdDisable} = '0;
        shortRec = 1'b0;
        resetCause = '0;
        regBus = '0;
        {error_cnt, n_checks} = '0;
        rng = 32'h00016c13;
        {expRst, expBrk, expEn} = {6'h20, 2'h0};
        rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        rd_chk(`ADDR_LAST_RESET_SOURCE);
        rd_chk(`ADDR_LAST_RESET_SOURCE);
        rd_chk(`ADDR_BREAK_EXIT_STATUS);
        rd_chk(16'hfe02);
        // enable bit against break state, random lower data
        for (int i = 0; i < 4; i++)
        begin
            rng = xs(rng);
            inBreak = i[0];
            wr(`ADDR_BREAK_FLAG_CONTROL, {i[1], rng[6:0]});
            rd_chk(`ADDR_BREAK_FLAG_CONTROL);
            chk_bit("flagClearAllowed", !inBreak | expEn, clrOk);
        end
        inBreak = 1'b0;
        // wait woken by interrupt, watchdog option both ways
        for (int i = 0; i < 2; i++)
        begin
            wdDisable = i[0];
            enter(1'b0);
            rng = xs(rng);
            repeat (rng[2:0]) @(negedge ref_clk);
            cpuIrq = 1'b1;
            run_back(20);
            chk_reg("wakeLatency", 8'h03, n[7:0]);
            chk_bit("stackStart", 1'b1, stackStart);
            cpuIrq = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        // wait left by break, then by the reset pin
        enter(1'b0);
        breakIrq = 1'b1;
        expBrk = 1'b1;
        run_back(20);
        chk_bit("exitEvt", 1'b1, exitEvt);
        breakIrq = 1'b0;
        rd_chk(`ADDR_BREAK_EXIT_STATUS);
        wr(`ADDR_BREAK_EXIT_STATUS, 8'h00);
        rd_chk(`ADDR_BREAK_EXIT_STATUS);
        enter(1'b0);
        resetPin = 1'b1;
        run_back(20);
        resetPin = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk_bit("exitEvt", 1'b0, exitEvt);
        // stop with long then short recovery; irq then break
        for (int j = 0; j < 2; j++)
        begin
            shortRec = j[0];
            enter(1'b1);
            repeat (3) @(negedge ref_clk);
            chk_bit("xtalEn", 1'b0, xtalEn);
            cpuIrq = !j[0];
            breakIrq = j[0];
            expBrk = j[0];
            run_back(LONG_REC + 40);
            chk_reg("recovery", j ? 8'(SHORT_REC) : 8'(LONG_REC), rec[7:0]);
            chk_bit("stackStart", !j[0], stackStart);
            {cpuIrq, breakIrq} = 2'h0;
            repeat (4) @(negedge ref_clk);
        end
        rd_chk(`ADDR_BREAK_EXIT_STATUS);
        // each reset cause, fetch qualifier, power-on override
        for (int k = 0; k < 6; k++)
        begin
            rst_evt(reset_cause_t'(6'h01 << k), 1'b1);
            rd_chk(`ADDR_LAST_RESET_SOURCE);
        end
        rst_evt(reset_cause_t'(6'h02), 1'b0);
        rd_chk(`ADDR_LAST_RESET_SOURCE);
        rst_evt(reset_cause_t'(6'h10), 1'b0);
        rst_evt(reset_cause_t'(6'h20), 1'b0);
        rd_chk(`ADDR_LAST_RESET_SOURCE);
        rd_chk(`ADDR_BREAK_EXIT_STATUS);
        // two wait wakes and one stop wake by interrupt, none by pin or break
        chk_reg("stackCnt", 8'h03, stackCnt[7:0]);
        give_verdict();
    end
endmodule
